// ==== logic/pbu_pkg.sv ====
// Shared constants and types for the player button user interface.
package pbu_pkg;

    // Clock and key sampling rate.
    localparam int unsigned CLK_HZ           = 200_000_000;
    localparam int unsigned KEY_SAMPLE_HZ    = 16;
    localparam int unsigned KEY_TICK_CYCLES  = CLK_HZ / KEY_SAMPLE_HZ;
    localparam int unsigned KEY_TICK_W       = 24;

    // Key positions on the key vector.
    localparam int unsigned NKEYS            = 6;
    localparam int unsigned KEY_POWER        = 0;
    localparam int unsigned KEY_VOL_DOWN     = 1;
    localparam int unsigned KEY_VOL_UP       = 2;
    localparam int unsigned KEY_PREVIOUS     = 3;
    localparam int unsigned KEY_NEXT         = 4;
    localparam int unsigned KEY_FEATURE      = 5;

    // Press timing, counted in key sample ticks.
    localparam int unsigned HOLD_W           = 7;
    localparam int unsigned LONG_PRESS_S     = 1;
    localparam int unsigned LONG_TICKS       = LONG_PRESS_S * KEY_SAMPLE_HZ;
    localparam int unsigned POWER_OFF_S      = 2;
    localparam int unsigned POWER_OFF_TICKS  = POWER_OFF_S * KEY_SAMPLE_HZ;
    localparam int unsigned FFWD_STEP_S      = 1;
    localparam int unsigned FFWD_STEP_SHIFT  = $clog2(FFWD_STEP_S * KEY_SAMPLE_HZ);

    // Pause timing.
    localparam int unsigned PAUSE_W          = 13;
    localparam int unsigned LP_PAUSE_S       = 4;
    localparam int unsigned LP_PAUSE_TICKS   = LP_PAUSE_S * KEY_SAMPLE_HZ;
    localparam int unsigned AUTO_OFF_MIN     = 5;
    localparam int unsigned AUTO_OFF_TICKS   = AUTO_OFF_MIN * 60 * KEY_SAMPLE_HZ;
    localparam int unsigned BLINK_W          = 3;
    localparam logic [BLINK_W-1:0] BLINK_HALF_TICKS = 3'h4;

    // Song control.
    localparam int unsigned RESTART_S        = 5;

    // Volume in half decibel steps; a larger value is louder.
    localparam int unsigned VOL_W            = 8;
    localparam logic [VOL_W-1:0] VOL_RESET   = 8'hC8;
    localparam logic [VOL_W-1:0] VOL_MAX     = 8'hFF;
    localparam int unsigned VOL_LONG_DB_PER_S = 8;
    localparam logic [VOL_W-1:0] VOL_LONG_STEP = VOL_W'(VOL_LONG_DB_PER_S * 2 / KEY_SAMPLE_HZ);

    // Loudness and sample rate.
    localparam int unsigned GAIN_W           = 8;
    localparam int          GAIN_DEFAULT_DB  = -6;
    localparam logic [GAIN_W-1:0] GAIN_DEFAULT_HDB = GAIN_W'(GAIN_DEFAULT_DB * 2);
    localparam int unsigned RATE_W           = 18;
    localparam int unsigned RATE_CAP_HZ      = 46875;
    localparam logic [RATE_W-1:0] RATE_CAP   = RATE_W'(RATE_CAP_HZ);

    typedef enum logic [4:0] {
        ST_OFF    = 5'h01,
        ST_BOOT   = 5'h02,
        ST_PLAY   = 5'h04,
        ST_PAUSE  = 5'h08,
        ST_LPAUSE = 5'h10
    } pbu_state_e;

    typedef struct packed {
        logic restart;
        logic prev;
        logic next;
        logic random_pick;
        logic rewind;
        logic ffwd;
        logic [2:0] ffwd_speed;
    } pbu_song_cmd_s;

    typedef struct packed {
        logic [NKEYS-1:0]      sync1;
        logic [NKEYS-1:0]      sync2;
        logic [NKEYS-1:0]      sync3;
        logic [NKEYS-1:0]      level;
        logic [KEY_TICK_W-1:0] cnt;
        logic                  tick;
    } pbu_smp_s;

    typedef struct packed {
        pbu_state_e                   st;
        logic [NKEYS-1:0]             key_prev;
        logic [NKEYS-1:0]             sup;
        logic [NKEYS-1:0][HOLD_W-1:0] hold;
        logic [VOL_W-1:0]             vol;
        logic [1:0]                   spatial;
        logic                         random;
        logic [PAUSE_W-1:0]           pause_ticks;
        logic [BLINK_W-1:0]           blink_cnt;
        logic                         blink;
        logic                         usb_act;
        pbu_song_cmd_s                cmd;
        logic [RATE_W-1:0]            rate;
        logic [GAIN_W-1:0]            gain;
    } pbu_ui_s;

endpackage : pbu_pkg

// ==== logic/pbu_key_sampler.sv ====
// Key line synchroniser and key sample tick divider.
`timescale 1ns/1ps
module pbu_key_sampler
    import pbu_pkg::*;
#(
    parameter int unsigned TICK_CYCLES = KEY_TICK_CYCLES
) (
    // Clock and reset.
    input  wire logic             clk_sys_i,
    input  wire logic             reset_n_i,
    // Raw key lines, high while pressed.
    input  wire logic [NKEYS-1:0] keys_raw_i,
    // Sample tick and filtered key levels.
    output logic                  tick_o,
    output logic [NKEYS-1:0]      keys_o
);

    pbu_smp_s         q;
    pbu_smp_s         d;
    logic [NKEYS-1:0] level_nxt;

    // A key level changes only once the second and third stages agree.
    genvar gi;
    generate
        for (gi = 0; gi < NKEYS; gi++) begin : g_key
            assign level_nxt[gi] = (q.sync2[gi] == q.sync3[gi]) ? q.sync3[gi] : q.level[gi];
        end
    endgenerate

    always_comb begin
        d       = q;
        d.sync1 = keys_raw_i;
        d.sync2 = q.sync1;
        d.sync3 = q.sync2;
        d.level = level_nxt;
        d.tick  = 1'b0;
        if (q.cnt == KEY_TICK_W'(TICK_CYCLES - 1)) begin
            d.cnt  = '0;
            d.tick = 1'b1;
        end else begin
            d.cnt = q.cnt + KEY_TICK_W'(1);
        end
    end

    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign tick_o = q.tick;
    assign keys_o = q.level;

endmodule : pbu_key_sampler

// ==== logic/pbu_player_ui.sv ====
// Six-key player user interface: power, pause, volume, song and feature control.
// Overview of operation
// RULE_01: Under one second short, else long press.
// RULE_02: Power key powers on; LED after boot.
// RULE_03: Short power press toggles pause and play.
// RULE_04: Power LED blinks while paused.
// RULE_05: Pause lasting seconds enters low-power pause.
// RULE_06: Power key held two seconds shuts down.
// RULE_07: Short volume press steps half decibel.
// RULE_08: Held volume key ramps eight dB/s.
// RULE_09: Previous restarts after five seconds, else back.
// RULE_10: Short next press advances song immediately.
// RULE_11: Long previous rewinds, long next fast-forwards.
// RULE_12: Long feature toggles random, picks new song; the code picks a new song only when random is switched on.
// RULE_13: Feature LED lit while random play active.
// RULE_14: Short feature cycles four spatial settings.
// RULE_15: Loudness tag used, else minus six dB.
// RULE_16: In USB mode cap rate at 46875 Hz.
// RULE_17: Five minutes paused switches unit off.
// RULE_18: Fast-forward speeds up while key held.
// RULE_19: USB storage activity blinks LED until flush.
// RULE_20: Keys work without any file system.
// RULE_21: Keys sampled sixteen times per second.
// RULE_22: Pressed key line reads high.
// RULE_23: Short acts on release, long at threshold.
`timescale 1ns/1ps
module pbu_player_ui
    import pbu_pkg::*;
#(
    parameter int unsigned        TICK_CYCLES   = KEY_TICK_CYCLES,
    parameter logic [PAUSE_W-1:0] LP_TICKS      = PAUSE_W'(LP_PAUSE_TICKS),
    parameter logic [PAUSE_W-1:0] OFF_TICKS     = PAUSE_W'(AUTO_OFF_TICKS),
    parameter logic [VOL_W-1:0]   VOL_INIT      = VOL_RESET
) (
    // Clock and reset.
    input  wire logic              clk_sys_i,
    input  wire logic              reset_n_i,
    // Key lines: power, volume down, volume up, previous, next, feature.
    input  wire logic [NKEYS-1:0]  keys_i,
    // Player status.
    input  wire logic              boot_done_i,
    input  wire logic [7:0]        song_played_s_i,
    input  wire logic              gain_tag_valid_i,
    input  wire logic [GAIN_W-1:0] gain_tag_hdb_i,
    input  wire logic [RATE_W-1:0] sample_rate_i,
    // USB attachment and storage status.
    input  wire logic              usb_attached_i,
    input  wire logic              storage_busy_i,
    input  wire logic              fs_flushed_i,
    // Power and indicators.
    output logic                   power_en_o,
    output logic                   playing_o,
    output logic                   low_power_o,
    output logic                   power_led_o,
    output logic                   feature_led_o,
    // Audio settings.
    output logic [VOL_W-1:0]       volume_o,
    output logic [1:0]             spatial_mode_o,
    output logic                   random_o,
    output logic [GAIN_W-1:0]      level_adj_hdb_o,
    output logic [RATE_W-1:0]      play_rate_o,
    // Song commands.
    output pbu_song_cmd_s          song_cmd_o
);

    pbu_ui_s          q;
    pbu_ui_s          d;

    logic             tick;
    logic [NKEYS-1:0] keys;
    logic [NKEYS-1:0] pressed;
    logic [NKEYS-1:0] released;
    logic [NKEYS-1:0] short_hit;
    logic [NKEYS-1:0] long_hit;
    logic [NKEYS-1:0] long_held;
    logic             unit_on;

    pbu_key_sampler #(
        .TICK_CYCLES (TICK_CYCLES)
    ) u_pbu_key_sampler (
        .clk_sys_i  (clk_sys_i),
        .reset_n_i  (reset_n_i),
        .keys_raw_i (keys_i),      // RULE_22
        .tick_o     (tick),        // RULE_21
        .keys_o     (keys)
    );

    assign unit_on  = (q.st == ST_PLAY) || (q.st == ST_PAUSE) || (q.st == ST_LPAUSE);
    assign pressed  = keys & ~q.key_prev;
    assign released = ~keys & q.key_prev;

    // Classify presses by how many ticks the key has been down.
    genvar gk;
    generate
        for (gk = 0; gk < NKEYS; gk++) begin : g_press
            assign short_hit[gk] = released[gk] && !q.sup[gk] && (q.hold[gk] < HOLD_W'(LONG_TICKS));   // RULE_01 RULE_23
            assign long_hit[gk]  = keys[gk] && !q.sup[gk] && (q.hold[gk] == HOLD_W'(LONG_TICKS - 1)); // RULE_01 RULE_23
            assign long_held[gk] = keys[gk] && !q.sup[gk] && (q.hold[gk] >= HOLD_W'(LONG_TICKS - 1));
        end
    endgenerate

    always_comb begin
        d                 = q;
        d.cmd.restart     = 1'b0;
        d.cmd.prev        = 1'b0;
        d.cmd.next        = 1'b0;
        d.cmd.random_pick = 1'b0;
        d.rate = (usb_attached_i && sample_rate_i > RATE_CAP) ? RATE_CAP : sample_rate_i; // RULE_16
        d.gain = gain_tag_valid_i ? gain_tag_hdb_i : GAIN_DEFAULT_HDB;                  // RULE_15
        // Activity sets the flag and wins over a flush in the same cycle.
        if (!usb_attached_i) begin
            d.usb_act = 1'b0;
        end else if (storage_busy_i) begin
            d.usb_act = 1'b1;                                                           // RULE_19
        end else if (fs_flushed_i) begin
            d.usb_act = 1'b0;                                                           // RULE_19
        end

        if (q.st == ST_BOOT && boot_done_i) begin
            d.st = ST_PLAY;                                                             // RULE_02
        end

        // Key handling, blinking and pause timing advance only on sample ticks.
        if (tick) begin
            d.key_prev = keys;
            if (q.blink_cnt == BLINK_HALF_TICKS - 3'h1) begin
                d.blink_cnt = '0;
                d.blink     = ~q.blink;
            end else begin
                d.blink_cnt = q.blink_cnt + 3'h1;
            end

            // Hold counts saturate, so a very long hold never wraps back to a short press.
            for (int i = 0; i < NKEYS; i++) begin
                if (keys[i]) begin
                    if (q.hold[i] != '1) begin
                        d.hold[i] = q.hold[i] + HOLD_W'(1);
                    end
                end else begin
                    d.hold[i] = '0;
                    d.sup[i]  = 1'b0;
                end
            end

            case (q.st)
                ST_OFF: begin
                    // Only a fresh press powers up, so a held shutdown press cannot restart.
                    if (pressed[KEY_POWER]) begin
                        d.st             = ST_BOOT;                                     // RULE_02
                        d.sup[KEY_POWER] = 1'b1;
                    end
                end
                ST_PLAY: begin
                    d.pause_ticks = '0;
                    if (short_hit[KEY_POWER]) begin
                        d.st = ST_PAUSE;                                                // RULE_03
                    end
                end
                ST_PAUSE, ST_LPAUSE: begin
                    d.pause_ticks = q.pause_ticks + PAUSE_W'(1);
                    if (short_hit[KEY_POWER]) begin
                        d.st          = ST_PLAY;                                        // RULE_03
                        d.pause_ticks = '0;
                    end else if (q.pause_ticks == OFF_TICKS - PAUSE_W'(1)) begin
                        d.st = ST_OFF;                                                  // RULE_17
                    end else if (q.st == ST_PAUSE && q.pause_ticks == LP_TICKS - PAUSE_W'(1)) begin
                        d.st = ST_LPAUSE;                                               // RULE_05
                    end
                end
                default: begin
                end
            endcase

            // Key actions depend on key state, unit state and played time, never on the storage medium.
            if (unit_on) begin                                                          // RULE_20
                if (keys[KEY_POWER] && q.hold[KEY_POWER] == HOLD_W'(POWER_OFF_TICKS - 1)) begin
                    d.st             = ST_OFF;                                          // RULE_06
                    d.sup[KEY_POWER] = 1'b1;
                end
                if (short_hit[KEY_VOL_DOWN] || long_held[KEY_VOL_DOWN]) begin
                    d.vol = (q.vol > VOL_LONG_STEP) ? q.vol - VOL_LONG_STEP : '0;      // RULE_07 RULE_08
                end else if (short_hit[KEY_VOL_UP] || long_held[KEY_VOL_UP]) begin
                    d.vol = (q.vol < VOL_MAX - VOL_LONG_STEP) ? q.vol + VOL_LONG_STEP : VOL_MAX; // RULE_07 RULE_08
                end
                if (short_hit[KEY_PREVIOUS]) begin
                    if (song_played_s_i >= 8'(RESTART_S)) begin
                        d.cmd.restart = 1'b1;                                           // RULE_09
                    end else begin
                        d.cmd.prev = 1'b1;                                              // RULE_09
                    end
                end
                if (short_hit[KEY_NEXT]) begin
                    d.cmd.next = 1'b1;                                                  // RULE_10
                end
                if (long_hit[KEY_FEATURE]) begin
                    d.random          = ~q.random;                                      // RULE_12
                    d.cmd.random_pick = ~q.random;                                      // RULE_12
                end
                if (short_hit[KEY_FEATURE]) begin
                    d.spatial = q.spatial + 2'h1;                                       // RULE_14
                end
            end
        end

        // Seek levels use the next key view, so they drop on the release tick itself.
        d.cmd.rewind     = (d.st == ST_PLAY) && d.key_prev[KEY_PREVIOUS] && !d.sup[KEY_PREVIOUS]
                           && d.hold[KEY_PREVIOUS] >= HOLD_W'(LONG_TICKS);              // RULE_11
        d.cmd.ffwd       = (d.st == ST_PLAY) && d.key_prev[KEY_NEXT] && !d.sup[KEY_NEXT]
                           && d.hold[KEY_NEXT] >= HOLD_W'(LONG_TICKS);                  // RULE_11
        d.cmd.ffwd_speed = d.cmd.ffwd ? 3'((d.hold[KEY_NEXT] - HOLD_W'(LONG_TICKS)) >> FFWD_STEP_SHIFT) + 3'h1
                                      : 3'h0;                                           // RULE_18
    end

    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            q       <= '0;
            q.st    <= ST_OFF;
            q.vol   <= VOL_INIT;
            q.sup   <= '1;
        end else begin
            q <= d;
        end
    end

    assign power_en_o      = (q.st != ST_OFF);
    assign playing_o       = (q.st == ST_PLAY);
    assign low_power_o     = (q.st == ST_LPAUSE);
    assign power_led_o     = usb_attached_i ? (q.usb_act && q.blink)                   // RULE_19
                           : (q.st == ST_PLAY) || ((q.st == ST_PAUSE || q.st == ST_LPAUSE) && q.blink); // RULE_02 RULE_04
    assign feature_led_o   = q.random;                                                  // RULE_13

    assign volume_o        = q.vol;
    assign spatial_mode_o  = q.spatial;
    assign random_o        = q.random;
    assign level_adj_hdb_o = q.gain;
    assign play_rate_o     = q.rate;
    assign song_cmd_o      = q.cmd;

    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!reset_n_i);

    a_led_dark_off: assert property (q.st == ST_OFF || q.st == ST_BOOT |-> !power_led_o || usb_attached_i) // RULE_02
        else $error("power LED lit before boot completed");

    a_led_steady_play: assert property (q.st == ST_PLAY && !usb_attached_i |-> power_led_o) // RULE_02
        else $error("power LED not steady while playing");

    a_led_blinks_pause: assert property (q.st == ST_PAUSE && !usb_attached_i && !q.blink |-> !power_led_o) // RULE_04
        else $error("power LED not blinking in pause");

    a_pause_toggle: assert property (tick && q.st == ST_PLAY && short_hit[KEY_POWER] && !keys[KEY_POWER] // RULE_03
                                     |=> q.st == ST_PAUSE)
        else $error("short power press did not pause");

    a_lp_pause_entry: assert property (q.st == ST_LPAUSE |-> q.pause_ticks >= LP_TICKS) // RULE_05
        else $error("low-power pause entered too early");

    a_power_hold_off: assert property (tick && unit_on && keys[KEY_POWER] // RULE_06
                                       && q.hold[KEY_POWER] == HOLD_W'(POWER_OFF_TICKS - 1) |=> q.st == ST_OFF)
        else $error("two second power hold did not shut down");

    a_vol_ramp_down: assert property (tick && unit_on && keys == 6'h02 && q.vol > VOL_LONG_STEP // RULE_08
                                      && q.hold[KEY_VOL_DOWN] >= HOLD_W'(LONG_TICKS)
                                      |=> q.vol == $past(q.vol) - VOL_LONG_STEP)
        else $error("held volume key did not ramp");

    a_prev_restart: assert property (tick && unit_on && short_hit[KEY_PREVIOUS] // RULE_09
                                     && song_played_s_i >= 8'(RESTART_S) |=> song_cmd_o.restart && !song_cmd_o.prev)
        else $error("previous key did not restart song");

    a_random_pick: assert property (song_cmd_o.random_pick |-> random_o && feature_led_o) // RULE_12
        else $error("random pick without random play");

    a_auto_off: assert property (tick && q.st == ST_LPAUSE && !short_hit[KEY_POWER] // RULE_17
                                 && q.pause_ticks == OFF_TICKS - PAUSE_W'(1) |=> q.st == ST_OFF)
        else $error("pause timeout did not power off");

    a_rate_cap: assert property (usb_attached_i && sample_rate_i > RATE_CAP |=> play_rate_o == RATE_CAP) // RULE_16
        else $error("USB sample rate not capped");

    a_gain_default: assert property (!gain_tag_valid_i |=> level_adj_hdb_o == GAIN_DEFAULT_HDB) // RULE_15
        else $error("default level adjustment not applied");

    a_ffwd_speed: assert property (song_cmd_o.ffwd && tick && keys[KEY_NEXT] |=> song_cmd_o.ffwd_speed // RULE_18
                                   >= $past(song_cmd_o.ffwd_speed))
        else $error("fast-forward speed decreased while held");

    a_power_on: assert property (tick && q.st == ST_OFF && pressed[KEY_POWER] |=> power_en_o) // RULE_02
        else $error("fresh power press did not power up");

    a_next_pulse: assert property (tick && unit_on && short_hit[KEY_NEXT] // RULE_10
                                   |=> song_cmd_o.next ##1 !song_cmd_o.next)
        else $error("next key did not give a one-cycle pulse");

    a_spatial_step: assert property (tick && unit_on && short_hit[KEY_FEATURE] // RULE_14
                                     |=> spatial_mode_o == $past(spatial_mode_o) + 2'h1)
        else $error("short feature press did not step spatial mode");

    // Main scenarios that the bench must reach.
    c_power_on: cover property (q.st == ST_BOOT ##[1:20] q.st == ST_PLAY);
    c_pause_play: cover property (q.st == ST_PAUSE ##[1:200] q.st == ST_PLAY);
    c_random_on: cover property (song_cmd_o.random_pick);
    c_ffwd: cover property (song_cmd_o.ffwd_speed == 3'h2);
    c_auto_off: cover property (q.st == ST_LPAUSE ##1 q.st == ST_OFF);

endmodule : pbu_player_ui

// ==== testbench/pbu_key_pad.sv ====
// Key pad model: six push buttons, each with a pull-down on its line.
`timescale 1ns/1ps
module pbu_key_pad
    import pbu_pkg::*;
(
    // Button presses requested by the bench.
    input  wire logic [NKEYS-1:0] press_i,
    // Key lines towards the player.
    output logic      [NKEYS-1:0] keys_o
);
    // A pressed button ties its line high; the pull-down holds it low otherwise.
    assign keys_o = press_i;
endmodule : pbu_key_pad

// ==== testbench/tb_top.sv ====
// Self-checking bench for the player button interface.
`timescale 1ns/1ps
module tb_top;
    import pbu_pkg::*;
    localparam int unsigned TC = 8;
    logic              clk_sys_i = 1'b0;
    logic              reset_n_i = 1'b0;
    logic [NKEYS-1:0]  press     = '0;
    logic [NKEYS-1:0]  keys;
    logic              boot = 1'b0, tag_ok = 1'b0, usb = 1'b0, busy = 1'b0, flushed = 1'b0;
    logic [7:0]        played = 8'h00;
    logic [GAIN_W-1:0] tag = 8'h00;
    logic [RATE_W-1:0] rate = 18'h0_0000;
    logic              pwr, play, lowp, pled, fled, rnd;
    logic [VOL_W-1:0]  vol;
    logic [1:0]        spat;
    logic [GAIN_W-1:0] adj;
    logic [RATE_W-1:0] prate;
    pbu_song_cmd_s     cmd;
    int                err_total = 0, check_count = 0, cyc = 0;
    int                n_next = 0, n_prev = 0, n_rst = 0, n_pick = 0, n_rew = 0, max_spd = 0;
    logic [31:0]       seed = 32'h0000_cbbe;

    pbu_key_pad u_pbu_key_pad (.press_i(press), .keys_o(keys));
    pbu_player_ui #(.TICK_CYCLES(TC), .LP_TICKS(13'h0004), .OFF_TICKS(13'h0018)) u_pbu_player_ui (
        .clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .keys_i(keys), .boot_done_i(boot),
        .song_played_s_i(played), .gain_tag_valid_i(tag_ok), .gain_tag_hdb_i(tag), .sample_rate_i(rate),
        .usb_attached_i(usb), .storage_busy_i(busy), .fs_flushed_i(flushed), .power_en_o(pwr),
        .playing_o(play), .low_power_o(lowp), .power_led_o(pled), .feature_led_o(fled), .volume_o(vol),
        .spatial_mode_o(spat), .random_o(rnd), .level_adj_hdb_o(adj), .play_rate_o(prate), .song_cmd_o(cmd));

    always #2.5 clk_sys_i = ~clk_sys_i;

    // Pulse counters, so one-cycle commands are never missed.
    always @(posedge clk_sys_i) begin
        cyc <= cyc + 1;
        n_next <= n_next + cmd.next;
        n_prev <= n_prev + cmd.prev;
        n_rst <= n_rst + cmd.restart;
        n_pick <= n_pick + cmd.random_pick;
        n_rew <= n_rew + cmd.rewind;
        if (cmd.ffwd && cmd.ffwd_speed > max_spd) max_spd <= cmd.ffwd_speed;
        if (cyc == 20000) begin
            err_total++;
            test_done();
        end
    end

    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction : lfsr

    function automatic logic [VOL_W-1:0] vol_exp(input logic [VOL_W-1:0] v, input logic up);
        if (up) return (v == VOL_MAX) ? v : v + 1'b1;
        return (v == '0) ? v : v - 1'b1;
    endfunction : vol_exp

    function automatic logic [RATE_W-1:0] rate_exp(input logic u, input logic [RATE_W-1:0] r);
        return (u && r > RATE_CAP) ? RATE_CAP : r;
    endfunction : rate_exp

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        check_count++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH t=%0t %s got %0h exp %0h", $time, what, got, exp);
        end
    endtask : chk

    task automatic chk_in(input logic [31:0] got, input logic [31:0] lo, input logic [31:0] hi, input string what);
        check_count++;
        if (!(got >= lo && got <= hi)) begin
            err_total++;
            $display("MISMATCH t=%0t %s got %0h range %0h..%0h", $time, what, got, lo, hi);
        end
    endtask : chk_in

    // Holds one button for a whole number of sample ticks, then lets the release settle.
    task automatic hit(input int unsigned k, input int unsigned ticks);
        press[k] = 1'b1;
        repeat (ticks * TC) @(negedge clk_sys_i);
        press[k] = 1'b0;
        repeat (3 * TC) @(negedge clk_sys_i);
    endtask : hit

    task automatic led_win(input int unsigned n, output int hi);
        hi = 0;
        repeat (n) begin
            @(negedge clk_sys_i);
            hi += pled;
        end
    endtask : led_win

    task automatic test_done();
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : test_done

    initial begin
        logic [VOL_W-1:0] ev;
        int               hi;
        repeat (16) @(negedge clk_sys_i);
        chk(vol, VOL_RESET, "volume at reset");
        chk(pwr, 0, "off at reset");
        reset_n_i = 1'b1;
        repeat (2 * TC) @(negedge clk_sys_i);
        hit(KEY_VOL_UP, 3);
        chk(vol, VOL_RESET, "keys ignored while off");
        hit(KEY_POWER, 3);
        chk(pwr, 1, "power on");
        boot = 1'b1;
        repeat (2) @(negedge clk_sys_i);
        chk({play, pled}, 2'b11, "playing with lit led");
        hit(KEY_VOL_UP, 3);
        ev = vol_exp(VOL_RESET, 1'b1);
        chk(vol, ev, "short volume up");
        for (int i = 0; i < 6; i++) begin
            seed = lfsr(seed);
            hit(seed[0] ? KEY_VOL_UP : KEY_VOL_DOWN, 1 + seed[3:1]);
            ev = vol_exp(ev, seed[0]);
            chk(vol, ev, "random short volume step");
        end
        hit(KEY_VOL_UP, 80);
        chk(vol, VOL_MAX, "held volume saturates");
        hit(KEY_VOL_DOWN, 24);
        chk_in(vol, VOL_MAX - 11, VOL_MAX - 8, "held volume rate");
        hit(KEY_NEXT, 2);
        chk(n_next, 1, "next song");
        played = 8'h05;
        hit(KEY_PREVIOUS, 2);
        chk(n_rst, 1, "restart at five seconds");
        played = 8'h04;
        hit(KEY_PREVIOUS, 2);
        chk(n_prev, 1, "previous below five seconds");
        hit(KEY_NEXT, 48);
        chk(max_spd, 3, "fast forward speeds up");
        chk(n_next, 1, "no short action after long");
        hit(KEY_PREVIOUS, 20);
        chk_in(n_rew, 24, 48, "rewind while held");
        for (int i = 1; i <= 4; i++) begin
            hit(KEY_FEATURE, 2);
            chk(spat, i % 4, "spatial mode cycle");
        end
        hit(KEY_FEATURE, 20);
        chk({rnd, fled}, 2'b11, "random on with led");
        chk(n_pick, 1, "random pick on enable");
        hit(KEY_FEATURE, 20);
        chk({rnd, fled, spat}, 4'h0, "random off, spatial kept");
        chk(n_pick, 1, "no pick on disable");
        for (int i = 0; i < 8; i++) begin
            seed = lfsr(seed);
            usb = (i < 3) | seed[4];
            tag_ok = seed[5];
            tag = seed[15:8];
            rate = RATE_W'((i < 3) ? RATE_CAP + 1 - i : seed[31:14]);
            repeat (2) @(negedge clk_sys_i);
            chk(prate, rate_exp(usb, rate), "rate cap");
            chk(adj, tag_ok ? tag : GAIN_DEFAULT_HDB, "level adjust");
        end
        usb = 1'b1;
        busy = 1'b1;
        @(negedge clk_sys_i);
        busy = 1'b0;
        led_win(20 * TC, hi);
        chk_in(hi, 1, 20 * TC - 1, "led blinks on activity");
        flushed = 1'b1;
        @(negedge clk_sys_i);
        flushed = 1'b0;
        led_win(20 * TC, hi);
        chk(hi, 0, "led dark after flush");
        usb = 1'b0;
        hit(KEY_POWER, 2);
        chk(play, 0, "pause");
        led_win(5 * TC, hi);
        chk_in(hi, 1, 5 * TC - 1, "led blinks in pause");
        chk({lowp, pwr}, 2'b11, "low-power pause");
        hit(KEY_POWER, 2);
        chk({play, lowp}, 2'b10, "play again");
        hit(KEY_POWER, 2);
        repeat (24 * TC) @(negedge clk_sys_i);
        chk(pwr, 0, "auto off after pause");
        hit(KEY_POWER, 2);
        repeat (2) @(negedge clk_sys_i);
        hit(KEY_POWER, 24);
        chk({pwr, play}, 2'b11, "long power under two seconds");
        hit(KEY_POWER, 33);
        chk(pwr, 0, "power off after two seconds");
        test_done();
    end
endmodule : tb_top
